// File: design/gtu_pkg.sv
// Constants, control layout and register map of the general timer unit
`default_nettype none
package gtu_pkg;
  // =========================================================
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] VAL_OFS = 8'h20;
  localparam logic [7:0] CAPREG_OFS = 8'h40;
  localparam logic [7:0] STATUS_OFS = 8'h44;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] VAL_RST = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // =========================================================
  // Timer indices
  localparam int NUM_TIMERS = 5;
  localparam int NUM_PINS = 11;
  localparam int T_AUXL = 0;
  localparam int T_CORE = 1;
  localparam int T_AUXH = 2;
  localparam int T_SAUX = 3;
  localparam int T_SMAIN = 4;
  localparam int FIRST_M2 = 3;
  localparam int DIR_BASE = 5;
  localparam int CAP_PIN = 10;
  // =========================================================
  // Count resolution, log2 of system clocks per base tick
  localparam int M1_BASE_LOG = 2;
  localparam int M2_BASE_LOG = 1;
  localparam int PRE_W = 10;
  // =========================================================
  // Modes and control fields
  typedef enum logic [2:0] {
    MODE_TIMER = 3'h0,
    MODE_GATE_LO = 3'h1,
    MODE_GATE_HI = 3'h2,
    MODE_COUNTER = 3'h3,
    MODE_INCR = 3'h4,
    MODE_RELOAD = 3'h5,
    MODE_CAPTURE = 3'h6
  } gtu_mode_e;
  typedef struct packed {
    logic latch_clk;
    logic capreg_reload;
    logic cap_core_pins;
    logic clr_after_cap;
    logic tout_en;
    logic [1:0] edge_sel;
    logic ext_dir;
    logic down;
    logic run;
    gtu_mode_e mode;
    logic [2:0] prescale;
  } gtu_ctrl_s;
endpackage : gtu_pkg
`default_nettype wire

// File: design/gtu_timer.sv
// One 16-bit up/down timer cell with load and wrap pulse
`default_nettype none
module gtu_timer (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic step_in,
  input wire logic down_in,
  input wire logic load_in,
  input wire logic [15:0] load_val_in,
  output logic [15:0] cnt_out,
  output logic wrap_out
);
  logic [15:0] cnt_ff;

  // =========================================================
  // Counter
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      cnt_ff <= gtu_pkg::VAL_RST;
    else if (load_in)
      cnt_ff <= load_val_in;
    else if (step_in)
      cnt_ff <= down_in ? cnt_ff - 16'h0001 : cnt_ff + 16'h0001;
  end

  // Overflow or underflow on this step
  assign wrap_out = step_in && (down_in ? (cnt_ff == 16'h0000) : (cnt_ff == 16'hffff));
  assign cnt_out = cnt_ff;
endmodule : gtu_timer
`default_nettype wire

// File: design/gtu_top.sv
// General timer unit: two timer modules behind an AXI4-Lite slave
//
// Overview of operation
// - Five 16-bit timers, three plus two
// - Chaining only inside a module, via latches
// - First-module timers: timer, gated, counter, incremental
// - Timer counts prescaled clock; counter counts edges
// - Gated mode counts only at gate level
// - First module base tick is 4 clocks
// - Software direction, optionally flipped by pin
// - Incremental mode decodes quadrature A and B
// - Core latch toggles on wrap, drives pin
// - Core latch may clock either aux timer
// - Aux as capture or reload stops counting
// - Capture copies core timer on pin edge
// - Reload core from aux on pin/latch edge
// - Alternate reloads give continuous PWM
// - Second module: two timers, capreg, 2 clocks
// - Second module counts prescaled clock or pins
// - Second latch toggles, clocks aux, drives pin
// - Main wraps go out and reload main
// - Capture pin copies aux, optional clear
// - Core pin edges as alternative capture trigger
`default_nettype none
module gtu_top (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [4:0] timer_input_pin_in,
  input wire logic [4:0] timer_direction_pin_in,
  input wire logic capture_input_pin_in,
  output logic core_toggle_output_pin_out,
  output logic second_toggle_output_pin_out,
  output logic second_main_wrap_out,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int NT = gtu_pkg::NUM_TIMERS;
  localparam int NP = gtu_pkg::NUM_PINS;

  gtu_pkg::gtu_ctrl_s ctrl_ff [NT];
  logic [NP-1:0] sync1_ff;
  logic [NP-1:0] sync2_ff;
  logic [NP-1:0] samp_ff;
  logic [NP-1:0] prev_ff;
  logic [NP-1:0] pin_rise;
  logic [NP-1:0] pin_fall;
  logic [NP-1:0] samp_en;
  logic [gtu_pkg::PRE_W-1:0] pre_ff;
  logic base1;
  logic base2;
  logic core_tl_ff;
  logic core_tl_prev_ff;
  logic sec_tl_ff;
  logic sec_tl_prev_ff;
  logic [15:0] capreg_ff;
  logic [NT-1:0] step;
  logic [NT-1:0] down;
  logic [NT-1:0] load;
  logic [15:0] load_val [NT];
  logic [15:0] cnt [NT];
  logic [NT-1:0] wrap;
  logic [NT-1:0] tick;
  logic [NT-1:0] trig;
  logic cap2_trig;
  logic [7:0] awaddr_ff;
  logic aw_ok_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic w_ok_ff;
  logic aw_hs;
  logic w_hs;
  logic do_wr;
  logic nxt_aw_ok;
  logic nxt_w_ok;
  logic [15:0] wr16;
  logic [NT-1:0] sw_ctrl_wr;
  logic [NT-1:0] sw_val_wr;
  logic sw_cap_wr;
  logic wr_hit;

  // Tick for a prescale exponent on top of a module base rate
  function automatic logic pre_tick(input logic [gtu_pkg::PRE_W-1:0] pre, input logic [2:0] ex, input int base);
    logic [gtu_pkg::PRE_W-1:0] mask;
    mask = gtu_pkg::PRE_W'((1 << (base + int'(ex))) - 1);
    return &(pre | ~mask);
  endfunction : pre_tick

  function automatic logic edge_pick(input logic [1:0] sel, input logic r, input logic f);
    return (sel[0] && r) || (sel[1] && f);
  endfunction : edge_pick

  // =========================================================
  // Pin synchronisers and module-rate sampling
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end
    else
    begin
      sync1_ff <= {capture_input_pin_in, timer_direction_pin_in, timer_input_pin_in};
      sync2_ff <= sync1_ff;
    end
  end

  generate
    for (genvar p = 0; p < NP; p++)
    begin : g_samp
      localparam bit IS_M2 = (p == gtu_pkg::CAP_PIN) || ((p % gtu_pkg::DIR_BASE) >= gtu_pkg::FIRST_M2);
      assign samp_en[p] = IS_M2 ? base2 : base1;
      always_ff @(posedge clk_in)
      begin
        if (!rst_n_in)
          samp_ff[p] <= 1'b0;
        else if (samp_en[p])
          samp_ff[p] <= sync2_ff[p];
      end
    end
  endgenerate

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      prev_ff <= '0;
    else
      prev_ff <= samp_ff;
  end

  // One-cycle pulse per sampled change
  assign pin_rise = samp_ff & ~prev_ff;
  assign pin_fall = ~samp_ff & prev_ff;

  // =========================================================
  // Prescaler
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      pre_ff <= '0;
    else
      pre_ff <= pre_ff + gtu_pkg::PRE_W'(1);
  end

  assign base1 = pre_tick(pre_ff, 3'h0, gtu_pkg::M1_BASE_LOG);
  assign base2 = pre_tick(pre_ff, 3'h0, gtu_pkg::M2_BASE_LOG);

  // =========================================================
  // Count enables and directions
  always_comb
  begin
    logic lr;
    logic lf;
    logic a_edge;
    lr = 1'b0;
    lf = 1'b0;
    a_edge = 1'b0;
    for (int i = 0; i < NT; i++)
    begin
      tick[i] = pre_tick(pre_ff, ctrl_ff[i].prescale,
        (i >= gtu_pkg::FIRST_M2) ? gtu_pkg::M2_BASE_LOG : gtu_pkg::M1_BASE_LOG);
      lr = 1'b0;
      lf = 1'b0;
      if (i == gtu_pkg::T_AUXL || i == gtu_pkg::T_AUXH)
      begin
        lr = core_tl_ff && !core_tl_prev_ff;
        lf = !core_tl_ff && core_tl_prev_ff;
      end
      else if (i == gtu_pkg::T_SAUX)
      begin
        lr = sec_tl_ff && !sec_tl_prev_ff;
        lf = !sec_tl_ff && sec_tl_prev_ff;
      end
      trig[i] = ctrl_ff[i].latch_clk ? edge_pick(ctrl_ff[i].edge_sel, lr, lf)
        : edge_pick(ctrl_ff[i].edge_sel, pin_rise[i], pin_fall[i]);
      down[i] = ctrl_ff[i].down ^ (ctrl_ff[i].ext_dir && samp_ff[gtu_pkg::DIR_BASE + i]);
      step[i] = 1'b0;
      a_edge = pin_rise[i] || pin_fall[i];
      unique case (ctrl_ff[i].mode)
        gtu_pkg::MODE_TIMER:
          step[i] = ctrl_ff[i].run && tick[i];
        gtu_pkg::MODE_GATE_LO:
          step[i] = ctrl_ff[i].run && tick[i] && !samp_ff[i];
        gtu_pkg::MODE_GATE_HI:
          step[i] = ctrl_ff[i].run && tick[i] && samp_ff[i];
        gtu_pkg::MODE_COUNTER:
          step[i] = ctrl_ff[i].run && trig[i];
        gtu_pkg::MODE_INCR:
        begin
          step[i] = ctrl_ff[i].run && (a_edge || pin_rise[gtu_pkg::DIR_BASE + i]
            || pin_fall[gtu_pkg::DIR_BASE + i]);
          down[i] = a_edge ? (samp_ff[i] == prev_ff[gtu_pkg::DIR_BASE + i])
            : (samp_ff[gtu_pkg::DIR_BASE + i] != prev_ff[i]);
        end
        default:
          step[i] = 1'b0;
      endcase
    end
  end

  // =========================================================
  // Loads: software first, then capture and reload
  assign cap2_trig = ctrl_ff[gtu_pkg::T_SAUX].cap_core_pins
    ? (pin_rise[gtu_pkg::T_CORE] || pin_fall[gtu_pkg::T_CORE]
      || pin_rise[gtu_pkg::DIR_BASE + gtu_pkg::T_CORE] || pin_fall[gtu_pkg::DIR_BASE + gtu_pkg::T_CORE])
    : edge_pick(ctrl_ff[gtu_pkg::T_SAUX].edge_sel, pin_rise[gtu_pkg::CAP_PIN], pin_fall[gtu_pkg::CAP_PIN]);

  always_comb
  begin
    for (int i = 0; i < NT; i++)
    begin
      load[i] = sw_val_wr[i];
      load_val[i] = wr16;
    end
    if (!sw_val_wr[gtu_pkg::T_CORE])
    begin
      if (ctrl_ff[gtu_pkg::T_AUXL].mode == gtu_pkg::MODE_RELOAD && trig[gtu_pkg::T_AUXL])
      begin
        load[gtu_pkg::T_CORE] = 1'b1;
        load_val[gtu_pkg::T_CORE] = cnt[gtu_pkg::T_AUXL];
      end
      else if (ctrl_ff[gtu_pkg::T_AUXH].mode == gtu_pkg::MODE_RELOAD && trig[gtu_pkg::T_AUXH])
      begin
        load[gtu_pkg::T_CORE] = 1'b1;
        load_val[gtu_pkg::T_CORE] = cnt[gtu_pkg::T_AUXH];
      end
    end
    for (int i = 0; i < gtu_pkg::FIRST_M2; i += 2)
    begin
      if (!sw_val_wr[i] && ctrl_ff[i].mode == gtu_pkg::MODE_CAPTURE && trig[i])
      begin
        load[i] = 1'b1;
        load_val[i] = cnt[gtu_pkg::T_CORE];
      end
    end
    if (!sw_val_wr[gtu_pkg::T_SAUX] && cap2_trig && ctrl_ff[gtu_pkg::T_SAUX].clr_after_cap)
    begin
      load[gtu_pkg::T_SAUX] = 1'b1;
      load_val[gtu_pkg::T_SAUX] = 16'h0000;
    end
    if (!sw_val_wr[gtu_pkg::T_SMAIN] && wrap[gtu_pkg::T_SMAIN] && ctrl_ff[gtu_pkg::T_SMAIN].capreg_reload)
    begin
      load[gtu_pkg::T_SMAIN] = 1'b1;
      load_val[gtu_pkg::T_SMAIN] = capreg_ff;
    end
  end

  generate
    for (genvar t = 0; t < NT; t++)
    begin : g_tmr
      gtu_timer u_tmr (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .step_in(step[t]),
        .down_in(down[t]),
        .load_in(load[t]),
        .load_val_in(load_val[t]),
        .cnt_out(cnt[t]),
        .wrap_out(wrap[t])
      );
    end
  endgenerate

  // =========================================================
  // Toggle latches and pins
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      core_tl_ff <= 1'b0;
      core_tl_prev_ff <= 1'b0;
      sec_tl_ff <= 1'b0;
      sec_tl_prev_ff <= 1'b0;
    end
    else
    begin
      core_tl_ff <= core_tl_ff ^ wrap[gtu_pkg::T_CORE];
      core_tl_prev_ff <= core_tl_ff;
      sec_tl_ff <= sec_tl_ff ^ wrap[gtu_pkg::T_SMAIN];
      sec_tl_prev_ff <= sec_tl_ff;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      core_toggle_output_pin_out <= 1'b0;
      second_toggle_output_pin_out <= 1'b0;
      second_main_wrap_out <= 1'b0;
    end
    else
    begin
      core_toggle_output_pin_out <= core_tl_ff && ctrl_ff[gtu_pkg::T_CORE].tout_en;
      second_toggle_output_pin_out <= sec_tl_ff && ctrl_ff[gtu_pkg::T_SMAIN].tout_en;
      second_main_wrap_out <= wrap[gtu_pkg::T_SMAIN];
    end
  end

  // =========================================================
  // Capture/reload register
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      capreg_ff <= gtu_pkg::VAL_RST;
    else if (sw_cap_wr)
      capreg_ff <= wr16;
    else if (cap2_trig)
      capreg_ff <= cnt[gtu_pkg::T_SAUX];
  end

  // =========================================================
  // AXI4-Lite write channel
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign do_wr = aw_ok_ff && w_ok_ff && !s_axi_bvalid;
  assign nxt_aw_ok = (aw_ok_ff || aw_hs) && !do_wr;
  assign nxt_w_ok = (w_ok_ff || w_hs) && !do_wr;
  assign wr16 = {wstrb_ff[1] ? wdata_ff[15:8] : 8'h00, wstrb_ff[0] ? wdata_ff[7:0] : 8'h00};

  always_comb
  begin
    sw_cap_wr = do_wr && awaddr_ff == gtu_pkg::CAPREG_OFS;
    wr_hit = sw_cap_wr || (awaddr_ff == gtu_pkg::STATUS_OFS);
    for (int i = 0; i < NT; i++)
    begin
      sw_ctrl_wr[i] = do_wr && awaddr_ff == gtu_pkg::CTRL_OFS + 8'(4 * i);
      sw_val_wr[i] = do_wr && awaddr_ff == gtu_pkg::VAL_OFS + 8'(4 * i);
      wr_hit = wr_hit || awaddr_ff == gtu_pkg::CTRL_OFS + 8'(4 * i) || awaddr_ff == gtu_pkg::VAL_OFS + 8'(4 * i);
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      aw_ok_ff <= 1'b0;
      w_ok_ff <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
    end
    else
    begin
      aw_ok_ff <= nxt_aw_ok;
      w_ok_ff <= nxt_w_ok;
      s_axi_awready <= !nxt_aw_ok;
      s_axi_wready <= !nxt_w_ok;
      if (aw_hs)
        awaddr_ff <= {s_axi_awaddr[7:2], 2'b00};
      if (w_hs)
      begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= gtu_pkg::RESP_OKAY;
    end
    else if (do_wr)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? gtu_pkg::RESP_OKAY : gtu_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  generate
    for (genvar c = 0; c < NT; c++)
    begin : g_ctrl
      always_ff @(posedge clk_in)
      begin
        if (!rst_n_in)
          ctrl_ff[c] <= gtu_pkg::CTRL_RST;
        else if (sw_ctrl_wr[c])
          ctrl_ff[c] <= wr16;
      end
    end
  endgenerate

  // =========================================================
  // AXI4-Lite read channel
  function automatic logic [33:0] rd_word(input logic [7:0] a);
    logic [33:0] r;
    r = {gtu_pkg::RESP_SLVERR, 32'h00000000};
    for (int i = 0; i < NT; i++)
    begin
      if (a == gtu_pkg::CTRL_OFS + 8'(4 * i))
        r = {gtu_pkg::RESP_OKAY, 16'h0000, ctrl_ff[i]};
      if (a == gtu_pkg::VAL_OFS + 8'(4 * i))
        r = {gtu_pkg::RESP_OKAY, 16'h0000, cnt[i]};
    end
    if (a == gtu_pkg::CAPREG_OFS)
      r = {gtu_pkg::RESP_OKAY, 16'h0000, capreg_ff};
    if (a == gtu_pkg::STATUS_OFS)
      r = {gtu_pkg::RESP_OKAY, 30'h00000000, sec_tl_ff, core_tl_ff};
    return r;
  endfunction : rd_word

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= gtu_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      {s_axi_rresp, s_axi_rdata} <= rd_word({s_axi_araddr[7:2], 2'b00});
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
    else if (!s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end
endmodule : gtu_top
`default_nettype wire

// File: design/_unused_placeholder_removed.sv
// Intentionally empty file holder
`default_nettype none
`default_nettype wire

// File: tb/gtu_props.sv
// Port checker of the general timer unit
`default_nettype none
module gtu_props (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic core_toggle_output_pin_out,
  input wire logic second_toggle_output_pin_out,
  input wire logic second_main_wrap_out,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // ==========
  // Properties
  a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid held after handshake");
  a_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid held after handshake");
  a_rd_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_wr_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write answer late");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_unmap_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h48
    |=> s_axi_rresp == gtu_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_wrap_pulse: assert property (second_main_wrap_out |=> !second_main_wrap_out)
    else $error("wrap pulse too long");
  a_rst_quiet: assert property ($rose(rst_n_in) |-> !core_toggle_output_pin_out
    && !second_toggle_output_pin_out && !second_main_wrap_out && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active after reset");
  c_wrap: cover property (second_main_wrap_out);
  c_core_tog: cover property ($rose(core_toggle_output_pin_out));
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == gtu_pkg::RESP_SLVERR);
endmodule : gtu_props
bind gtu_top gtu_props u_props (.clk_in, .rst_n_in, .core_toggle_output_pin_out, .second_toggle_output_pin_out,
  .second_main_wrap_out, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready);
`default_nettype wire

// File: tb/gtu_pin_model.sv
// Pin-side model: timer, direction and capture pin levels
`default_nettype none
module gtu_pin_model (
  input wire logic clk_in,
  output logic [4:0] tin_out,
  output logic [4:0] tdir_out,
  output logic cap_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [10:0] pins_ff = 11'h000;
  assign tin_out = pins_ff[4:0];
  assign tdir_out = pins_ff[9:5];
  assign cap_out = pins_ff[10];
  // =========
  // Flip one pin, then hold it
  task automatic flip(input int idx, input int hold);
    @(posedge clk_in);
    pins_ff[idx] <= ~pins_ff[idx];
    repeat (hold) @(posedge clk_in);
  endtask : flip
endmodule : gtu_pin_model
`default_nettype wire

// File: tb/tb_gtu_top.sv
// Self-checking bench of the general timer unit
`default_nettype none
module tb_gtu_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [4:0] tin;
  logic [4:0] tdir;
  logic cap, ctog, stog, wrap;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int mismatches = 0;
  int checked = 0;
  always #2.5 clk_in = ~clk_in;
  gtu_pin_model pm (.clk_in, .tin_out(tin), .tdir_out(tdir), .cap_out(cap));
  gtu_top dut_u (.clk_in, .rst_n_in, .timer_input_pin_in(tin), .timer_direction_pin_in(tdir),
    .capture_input_pin_in(cap), .core_toggle_output_pin_out(ctog), .second_toggle_output_pin_out(stog),
    .second_main_wrap_out(wrap), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // =========
  // Reporting and bus tasks
  task automatic conclude;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic chk_rng(input string nm, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] got);
    checked++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      mismatches++;
      $display("BAD %s exp %h..%h got %h", nm, lo, hi, got);
    end
  endtask : chk_rng
  task automatic hang;
    mismatches++;
    $display("BAD wait exp answer got timeout");
    conclude();
  endtask : hang
  task automatic axw(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s, output logic [1:0] r);
    bit b;
    b = 0;
    @(posedge clk_in);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 40 && !b; n++)
    begin
      @(posedge clk_in);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        b = 1;
        s_axi_bready <= 1'b0;
        r = s_axi_bresp;
      end
    end
    if (!b)
      hang();
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit b;
    b = 0;
    @(posedge clk_in);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 40 && !b; n++)
    begin
      @(posedge clk_in);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        b = 1;
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        r = s_axi_rresp;
      end
    end
    if (!b)
      hang();
  endtask : axr
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [1:0] r;
    axw(a, d, 4'h3, r);
    chk("bresp", 32'(gtu_pkg::RESP_OKAY), 32'(r));
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    logic [1:0] r;
    axr(a, v, r);
    chk("rresp", 32'(gtu_pkg::RESP_OKAY), 32'(r));
  endtask : rd
  // =========
  // Scenarios
  task automatic t_regs;
    logic [7:0] ra [5] = '{8'h00, 8'h10, 8'h24, 8'h40, 8'h44};
    logic [31:0] v;
    logic [1:0] r;
    foreach (ra[i])
    begin
      rd(ra[i], v);
      chk("reset_val", 32'h0, v);
    end
    wr(8'h44, 16'hffff);
    rd(8'h44, v);
    chk("status_ro", 32'h0, v);
    axw(8'h00, 16'h1234, 4'h1, r);
    rd(8'h00, v);
    chk("strobe", 32'h34, v);
    wr(8'h00, 16'h0000);
    axr(8'h48, v, r);
    chk("unmap_rresp", 32'(gtu_pkg::RESP_SLVERR), 32'(r));
    axw(8'h48, 16'h1, 4'h3, r);
    chk("unmap_bresp", 32'(gtu_pkg::RESP_SLVERR), 32'(r));
    $display("test regs done");
  endtask : t_regs
  task automatic t_timer;
    logic [31:0] v;
    wr(8'h04, 16'h08c0);
    repeat (400) @(posedge clk_in);
    rd(8'h24, v);
    chk_rng("val1_down", 32'hff90, 32'hffa0, v);
    chk("core_tout", 32'h1, 32'(ctog));
    wr(8'h04, 16'h0000);
    wr(8'h24, 16'h0000);
    wr(8'h04, 16'h0042);
    repeat (400) @(posedge clk_in);
    rd(8'h24, v);
    chk_rng("val1_pre2", 32'd22, 32'd28, v);
    wr(8'h04, 16'h0000);
    $display("test timer done");
  endtask : t_timer
  task automatic t_count;
    logic [15:0] es [3] = '{16'h0258, 16'h0458, 16'h0658};
    int ex [3] = '{5, 5, 10};
    logic [31:0] v;
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h20, 16'h0000);
      wr(8'h00, es[i]);
      repeat (10) pm.flip(0, 10);
      rd(8'h20, v);
      chk("val0_cnt", ex[i], v);
    end
    wr(8'h00, 16'h0000);
    $display("test counter done");
  endtask : t_count
  task automatic t_gate;
    logic [31:0] v;
    wr(8'h28, 16'h0000);
    wr(8'h08, 16'h0050);
    pm.flip(2, 400);
    pm.flip(2, 400);
    rd(8'h28, v);
    chk_rng("val2_gate", 32'd94, 32'd106, v);
    wr(8'h08, 16'h0060);
    wr(8'h28, 16'h0000);
    for (int i = 0; i < 6; i++)
      pm.flip(i < 4 ? (i % 2 ? 7 : 2) : (i % 2 ? 2 : 7), 10);
    rd(8'h28, v);
    chk("val2_quad", 32'h2, v);
    wr(8'h08, 16'h0000);
    $display("test gate and quad done");
  endtask : t_gate
  task automatic t_wrap;
    int np;
    int nt;
    logic lt;
    np = 0;
    nt = 0;
    wr(8'h40, 16'hfff8);
    wr(8'h30, 16'hfff8);
    wr(8'h10, 16'h4840);
    repeat (40) @(posedge clk_in);
    lt = stog;
    repeat (160)
    begin
      @(posedge clk_in);
      if (wrap === 1'b1)
        np++;
      if (stog !== lt)
        nt++;
      lt = stog;
    end
    chk_rng("wraps", 32'd8, 32'd12, 32'(np));
    chk_rng("toggles", 32'd8, 32'd12, 32'(nt));
    wr(8'h10, 16'h0000);
    $display("test wrap done");
  endtask : t_wrap
  task automatic t_cap;
    logic [31:0] v;
    wr(8'h0c, 16'h1240);
    wr(8'h2c, 16'h0000);
    repeat (200) @(posedge clk_in);
    pm.flip(10, 20);
    rd(8'h40, v);
    chk_rng("capreg_pin", 32'd95, 32'd115, v);
    rd(8'h2c, v);
    chk_rng("val3_clr", 32'd0, 32'd30, v);
    pm.flip(10, 8);
    wr(8'h0c, 16'h3040);
    wr(8'h2c, 16'h0000);
    repeat (100) @(posedge clk_in);
    pm.flip(1, 10);
    rd(8'h40, v);
    chk_rng("capreg_core", 32'd45, 32'd65, v);
    $display("test capture done");
  endtask : t_cap
  task automatic t_pwm;
    int nt;
    logic lt;
    logic [31:0] v;
    nt = 0;
    wr(8'h20, 16'h000f);
    wr(8'h28, 16'h000f);
    wr(8'h00, 16'h8228);
    wr(8'h08, 16'h8428);
    wr(8'h24, 16'h0000);
    wr(8'h04, 16'h08c0);
    repeat (40) @(posedge clk_in);
    lt = ctog;
    repeat (640)
    begin
      @(posedge clk_in);
      if (ctog !== lt)
        nt++;
      lt = ctog;
    end
    chk_rng("pwm_toggles", 32'd8, 32'd12, 32'(nt));
    wr(8'h04, 16'h0000);
    wr(8'h00, 16'h0000);
    wr(8'h24, 16'h0000);
    wr(8'h08, 16'h0430);
    wr(8'h04, 16'h0040);
    repeat (200) @(posedge clk_in);
    pm.flip(2, 10);
    rd(8'h28, v);
    chk_rng("val2_capture", 32'd45, 32'd60, v);
    wr(8'h04, 16'h0000);
    wr(8'h08, 16'h0000);
    $display("test reload and capture done");
  endtask : t_pwm
  initial
  begin
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    t_regs();
    t_timer();
    t_count();
    t_gate();
    t_wrap();
    t_cap();
    t_pwm();
    conclude();
  end
endmodule : tb_gtu_top
`default_nettype wire
